// ### logic/cks_params.svh
// constants for the cpu clock source selection block: offsets, bit positions, reset values, timing
`ifndef CKS_PARAMS_SVH
`define CKS_PARAMS_SVH

// register byte offsets
`define CKS_OFS_PROC_CLK_CTRL 8'h00
`define CKS_OFS_MAIN_CLK_MODE 8'h04
`define CKS_OFS_OSC_MODE 8'h08
`define CKS_OFS_MAIN_OSC_CTRL 8'h0C
`define CKS_OFS_INT_OSC_MODE 8'h10
`define CKS_OFS_STAB_STATUS 8'h14
`define CKS_OFS_CPU_STATE 8'h18

// field positions
`define CKS_BIT_CPU_SRC_SEL 4
`define CKS_BIT_MAIN_SRC_SEL 0
`define CKS_BIT_MAIN_CLK_STATUS 1
`define CKS_BIT_PLL_SRC_SEL 2
`define CKS_BIT_EXT_INPUT_SEL 7
`define CKS_BIT_OSC_ENABLE_SEL 6
`define CKS_BIT_AMP_GAIN_SEL 0
`define CKS_BIT_MAIN_OSC_STOP 7
`define CKS_BIT_FAST_OSC_STABLE 7
`define CKS_BIT_FAST_OSC_STOP 0
`define CKS_BIT_STAB_DONE 0

// reset values
`define CKS_RST_MAIN_OSC_STOP 1'b1

// timing
`define CKS_CLK_PERIOD_NS 40
`define CKS_POC_PROC_NS 20000
`define CKS_FAST_SETTLE_CYC 16'h0040
`define CKS_OSC_STAB_TICKS 16'h0100

// axi responses
`define CKS_RESP_OKAY 2'h0
`define CKS_RESP_SLVERR 2'h2

`endif

// ### logic/cks_pkg.sv
// types shared by the cpu clock source selection block
package cks_pkg;
	typedef enum logic [2:0] {
		CKS_ST_RESET = 3'b000,
		CKS_ST_FAST = 3'b001,
		CKS_ST_HIGH = 3'b010,
		CKS_ST_HALT = 3'b011,
		CKS_ST_STOP = 3'b100
	} cks_state_t;
	typedef enum logic [0:0] {
		CKS_SRC_FAST = 1'b0,
		CKS_SRC_HIGH = 1'b1
	} cks_src_t;
endpackage

// ### logic/cks_switch_if.sv
// carrier between the clock state machine and the glitch free clock switch
`timescale 1ns/1ps
`default_nettype none
interface cks_switch_if;
	logic sel_high;
	logic ext_sel;
	logic run_cpu;
	logic run_periph;
	cks_pkg::cks_src_t active_src;
	modport ctl(output sel_high, output ext_sel, output run_cpu, output run_periph, input active_src);
	modport sw(input sel_high, input ext_sel, input run_cpu, input run_periph, output active_src);
endinterface
`default_nettype wire

// ### logic/cks_clock_switch.sv
// glitch free selection of the cpu and peripheral clock enables
`timescale 1ns/1ps
`default_nettype none
module cks_clock_switch (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// source ticks
	input wire logic fast_osc_tick,
	input wire logic crystal_tick,
	input wire logic ext_clk_tick,
	// control
	cks_switch_if.sw sw,
	// gated enables
	output logic cpu_clk_en,
	output logic periph_clk_en
);
	import cks_pkg::*;

	cks_src_t src_r;
	logic cpu_en_r;
	logic per_en_r;
	wire logic high_tick;
	wire logic sel_tick;
	wire logic take_high;

	assign high_tick = sw.ext_sel ? ext_clk_tick : crystal_tick;
	// change over only on a tick of the new source so no shortened period reaches the cpu
	assign take_high = sw.sel_high && (src_r == CKS_SRC_FAST) && high_tick;
	assign sel_tick = (src_r == CKS_SRC_HIGH) ? high_tick : fast_osc_tick;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			src_r <= CKS_SRC_FAST;
		end else if (take_high) begin
			src_r <= CKS_SRC_HIGH;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cpu_en_r <= 1'b0;
			per_en_r <= 1'b0;
		end else begin
			cpu_en_r <= sel_tick && sw.run_cpu && !take_high;
			per_en_r <= sel_tick && sw.run_periph && !take_high;
		end
	end

	assign cpu_clk_en = cpu_en_r;
	assign periph_clk_en = per_en_r;
	assign sw.active_src = src_r;
endmodule // cks_clock_switch
`default_nettype wire

// ### logic/cks_clock_select.sv
// cpu clock source selection: registers, clock state machine and oscillator controls
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cks_params.svh"
module cks_clock_select (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// oscillator ticks, one cycle each
	input wire logic fast_osc_tick,
	input wire logic crystal_tick,
	input wire logic ext_clk_tick,
	// power-on clear
	input wire logic power_on_clear_option,
	input wire logic supply_above_threshold,
	// cpu standby instructions
	input wire logic halt_exec,
	input wire logic stop_exec,
	input wire logic standby_release,
	// clock outputs
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic pll_clk_en,
	// oscillator controls
	output logic fast_osc_enable,
	output logic main_osc_enable,
	output logic ext_input_enable,
	output logic amp_high_gain,
	// state
	output cks_pkg::cks_state_t cpu_state
);
	import cks_pkg::*;

	localparam logic [9:0] POC_CYC = 10'((`CKS_POC_PROC_NS + `CKS_CLK_PERIOD_NS - 1) / `CKS_CLK_PERIOD_NS);

	// register index from a byte address; 7 means unmapped
	function automatic logic [2:0] reg_index(input logic [7:0] addr);
		case (addr)
			`CKS_OFS_PROC_CLK_CTRL: reg_index = 3'h0;
			`CKS_OFS_MAIN_CLK_MODE: reg_index = 3'h1;
			`CKS_OFS_OSC_MODE: reg_index = 3'h2;
			`CKS_OFS_MAIN_OSC_CTRL: reg_index = 3'h3;
			`CKS_OFS_INT_OSC_MODE: reg_index = 3'h4;
			`CKS_OFS_STAB_STATUS: reg_index = 3'h5;
			`CKS_OFS_CPU_STATE: reg_index = 3'h6;
			default: reg_index = 3'h7;
		endcase
	endfunction

	// control bits
	logic cpu_source_select_r;
	logic main_source_select_r;
	logic pll_source_select_r;
	logic external_input_select_r;
	logic oscillator_enable_select_r;
	logic amplifier_gain_select_r;
	logic main_oscillator_stop_r;
	logic fast_oscillator_stop_r;
	logic gain_locked_r;
	logic pll_locked_r;
	// status
	logic fast_oscillator_stable_flag_r;
	logic [15:0] fast_settle_r;
	logic [15:0] stab_cnt_r;
	logic stabilization_time_counter_status_r;
	cks_state_t state_r;
	cks_state_t state_nxt;
	logic [9:0] poc_cnt_r;
	// bus
	logic aw_held_r;
	logic [7:0] aw_addr_r;
	logic w_held_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	cks_switch_if sw_if ();

	cks_clock_switch u_switch (
		.mclk(mclk),
		.nrst(nrst),
		.fast_osc_tick(fast_osc_tick),
		.crystal_tick(crystal_tick),
		.ext_clk_tick(ext_clk_tick),
		.sw(sw_if.ctl),
		.cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en)
	);

	// write path: address and data are taken independently, then applied together
	wire logic do_write = aw_held_r && w_held_r && !bvalid_r;
	wire logic [2:0] wr_idx = reg_index(aw_addr_r);
	wire logic wr_lane = do_write && w_strb_r[0];
	wire logic wr_pcc = wr_lane && (wr_idx == 3'h0);
	wire logic wr_mcm = wr_lane && (wr_idx == 3'h1);
	wire logic wr_osc = wr_lane && (wr_idx == 3'h2);
	wire logic wr_moc = wr_lane && (wr_idx == 3'h3);
	wire logic wr_rcm = wr_lane && (wr_idx == 3'h4);
	wire logic [2:0] rd_idx = reg_index(s_axi_araddr);
	wire logic rd_take = s_axi_arvalid && !rvalid_r;
	wire logic on_high = (state_r == CKS_ST_HIGH) || (state_r == CKS_ST_HALT) || (state_r == CKS_ST_STOP);

	assign s_axi_awready = !aw_held_r;
	assign s_axi_wready = !w_held_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end else if (s_axi_awvalid && !aw_held_r) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end else if (s_axi_wvalid && !w_held_r) begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			bvalid_r <= 1'b0;
			bresp_r <= `CKS_RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r <= (wr_idx == 3'h7) ? `CKS_RESP_SLVERR : `CKS_RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// read data mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		case (rd_idx)
			3'h0: rd_mux[`CKS_BIT_CPU_SRC_SEL] = cpu_source_select_r;
			3'h1: begin
				rd_mux[`CKS_BIT_MAIN_SRC_SEL] = main_source_select_r;
				rd_mux[`CKS_BIT_MAIN_CLK_STATUS] = (sw_if.active_src == CKS_SRC_HIGH);
				rd_mux[`CKS_BIT_PLL_SRC_SEL] = pll_source_select_r;
			end
			3'h2: begin
				rd_mux[`CKS_BIT_EXT_INPUT_SEL] = external_input_select_r;
				rd_mux[`CKS_BIT_OSC_ENABLE_SEL] = oscillator_enable_select_r;
				rd_mux[`CKS_BIT_AMP_GAIN_SEL] = amplifier_gain_select_r;
			end
			3'h3: rd_mux[`CKS_BIT_MAIN_OSC_STOP] = main_oscillator_stop_r;
			3'h4: begin
				rd_mux[`CKS_BIT_FAST_OSC_STABLE] = fast_oscillator_stable_flag_r;
				rd_mux[`CKS_BIT_FAST_OSC_STOP] = fast_oscillator_stop_r;
			end
			3'h5: rd_mux[`CKS_BIT_STAB_DONE] = stabilization_time_counter_status_r;
			3'h6: rd_mux[2:0] = state_r;
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `CKS_RESP_OKAY;
		end else if (rd_take) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= (rd_idx == 3'h7) ? `CKS_RESP_SLVERR : `CKS_RESP_OKAY;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// control registers
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cpu_source_select_r <= 1'b0;
		end else if (wr_pcc) begin
			cpu_source_select_r <= w_data_r[`CKS_BIT_CPU_SRC_SEL];
		end
	end

	// main select cannot be cleared once the cpu has left the fast oscillator
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			main_source_select_r <= 1'b0;
		end else if (wr_mcm && !on_high) begin
			main_source_select_r <= w_data_r[`CKS_BIT_MAIN_SRC_SEL];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pll_source_select_r <= 1'b0;
			pll_locked_r <= 1'b0;
		end else if (wr_mcm && !pll_locked_r && (w_data_r[`CKS_BIT_PLL_SRC_SEL] != pll_source_select_r)) begin
			pll_source_select_r <= w_data_r[`CKS_BIT_PLL_SRC_SEL];
			pll_locked_r <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			external_input_select_r <= 1'b0;
			oscillator_enable_select_r <= 1'b0;
		end else if (wr_osc) begin
			external_input_select_r <= w_data_r[`CKS_BIT_EXT_INPUT_SEL];
			oscillator_enable_select_r <= w_data_r[`CKS_BIT_OSC_ENABLE_SEL];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			amplifier_gain_select_r <= 1'b0;
			gain_locked_r <= 1'b0;
		end else if (wr_osc && !gain_locked_r && (w_data_r[`CKS_BIT_AMP_GAIN_SEL] != amplifier_gain_select_r)) begin
			amplifier_gain_select_r <= w_data_r[`CKS_BIT_AMP_GAIN_SEL];
			gain_locked_r <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			main_oscillator_stop_r <= `CKS_RST_MAIN_OSC_STOP;
			fast_oscillator_stop_r <= 1'b0;
		end else begin
			if (wr_moc) begin
				main_oscillator_stop_r <= w_data_r[`CKS_BIT_MAIN_OSC_STOP];
			end
			if (wr_rcm) begin
				fast_oscillator_stop_r <= w_data_r[`CKS_BIT_FAST_OSC_STOP];
			end
		end
	end

	// fast oscillator settles a fixed number of cycles after it starts
	always_ff @(posedge mclk) begin
		if (!nrst || fast_oscillator_stop_r) begin
			fast_settle_r <= 16'h0000;
			fast_oscillator_stable_flag_r <= 1'b0;
		end else if (fast_settle_r != `CKS_FAST_SETTLE_CYC) begin
			fast_settle_r <= fast_settle_r + 16'h0001;
		end else begin
			fast_oscillator_stable_flag_r <= 1'b1;
		end
	end

	// crystal stabilization counts crystal ticks while the oscillator is allowed to run
	wire logic xtal_run = oscillator_enable_select_r && !main_oscillator_stop_r && !external_input_select_r;
	always_ff @(posedge mclk) begin
		if (!nrst || !xtal_run) begin
			stab_cnt_r <= 16'h0000;
			stabilization_time_counter_status_r <= 1'b0;
		end else if (stab_cnt_r == `CKS_OSC_STAB_TICKS) begin
			stabilization_time_counter_status_r <= 1'b1;
		end else if (crystal_tick) begin
			stab_cnt_r <= stab_cnt_r + 16'h0001;
		end
	end

	// power-on processing delay in the reset state
	always_ff @(posedge mclk) begin
		if (!nrst || state_r != CKS_ST_RESET || !supply_above_threshold) begin
			poc_cnt_r <= 10'h000;
		end else if (poc_cnt_r != POC_CYC) begin
			poc_cnt_r <= poc_cnt_r + 10'h001;
		end
	end

	wire logic poc_done = !power_on_clear_option || (poc_cnt_r == POC_CYC);
	wire logic want_high = pll_source_select_r && !cpu_source_select_r && main_source_select_r;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CKS_ST_RESET: if (poc_done) state_nxt = CKS_ST_FAST;
			CKS_ST_FAST: if (sw_if.active_src == CKS_SRC_HIGH) state_nxt = CKS_ST_HIGH;
			CKS_ST_HIGH: begin
				if (stop_exec) state_nxt = CKS_ST_STOP;
				else if (halt_exec) state_nxt = CKS_ST_HALT;
			end
			CKS_ST_HALT: if (standby_release) state_nxt = CKS_ST_HIGH;
			CKS_ST_STOP: if (standby_release) state_nxt = CKS_ST_HIGH;
			default: state_nxt = CKS_ST_RESET;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_r <= CKS_ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign sw_if.sel_high = want_high && (state_r == CKS_ST_FAST);
	assign sw_if.ext_sel = external_input_select_r;
	assign sw_if.run_cpu = (state_r == CKS_ST_FAST) || (state_r == CKS_ST_HIGH);
	assign sw_if.run_periph = (state_r != CKS_ST_RESET) && (state_r != CKS_ST_STOP);

	// the pll takes whichever high source is selected, so the external input feeds it too
	assign pll_clk_en = pll_source_select_r && (external_input_select_r ? (ext_clk_tick && ext_input_enable)
		: (crystal_tick && main_osc_enable));
	assign fast_osc_enable = !fast_oscillator_stop_r && (state_r != CKS_ST_STOP);
	assign main_osc_enable = xtal_run && (state_r != CKS_ST_STOP);
	assign ext_input_enable = oscillator_enable_select_r && !main_oscillator_stop_r && external_input_select_r;
	assign amp_high_gain = amplifier_gain_select_r;
	assign cpu_state = state_r;
endmodule // cks_clock_select
`default_nettype wire

// ### tb/cks_clock_select_asserts.sv
// concurrent checks on the ports of the clock source selection block
`timescale 1ns/1ps
`default_nettype none
module cks_clock_select_asserts (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// stimulus seen by the block, and its write response valid
	input wire logic power_on_clear_option,
	input wire logic halt_exec,
	input wire logic stop_exec,
	input wire logic fast_osc_tick,
	input wire logic crystal_tick,
	input wire logic ext_clk_tick,
	input wire logic s_axi_bvalid,
	// clocks, oscillator enables and state
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic pll_clk_en,
	input wire logic fast_osc_enable,
	input wire logic main_osc_enable,
	input wire cks_pkg::cks_state_t cpu_state
);
	import cks_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence high_then_stop;
		cpu_state == CKS_ST_HIGH && stop_exec;
	endsequence
	sequence settled_stop;
		cpu_state == CKS_ST_STOP && $past(cpu_state) == CKS_ST_STOP;
	endsequence
	reset_state_a: assert property ($rose(nrst) |-> cpu_state == CKS_ST_RESET && !cpu_clk_en && !s_axi_bvalid)
		else $error("state not cleared by reset");
	fast_start_a: assert property ($rose(nrst) && !power_on_clear_option |=> cpu_state == CKS_ST_FAST)
		else $error("no fast oscillator state after release");
	no_return_a: assert property (cpu_state == CKS_ST_HIGH |=> cpu_state != CKS_ST_FAST)
		else $error("returned from high clock to fast");
	halt_entry_a: assert property (cpu_state == CKS_ST_HIGH && halt_exec && !stop_exec |=> cpu_state == CKS_ST_HALT)
		else $error("halt not entered");
	stop_entry_a: assert property (high_then_stop |=> cpu_state == CKS_ST_STOP)
		else $error("stop not entered");
	stop_quiet_a: assert property (settled_stop |-> !(cpu_clk_en || periph_clk_en || fast_osc_enable || main_osc_enable))
		else $error("clock or oscillator active in stop");
	halt_gated_a: assert property (cpu_state == CKS_ST_HALT && $past(cpu_state) == CKS_ST_HALT |-> !cpu_clk_en)
		else $error("cpu clock runs in halt");
	fast_source_a: assert property (cpu_state == CKS_ST_FAST && $past(cpu_state, 2) == CKS_ST_FAST && cpu_clk_en
		|-> $past(fast_osc_tick))
		else $error("cpu clock not from fast oscillator");
	high_source_a: assert property (cpu_state == CKS_ST_HIGH && $past(cpu_state) == CKS_ST_HIGH && cpu_clk_en
		|-> $past(crystal_tick || ext_clk_tick))
		else $error("cpu clock not from high source");
	pll_feed_a: assert property (pll_clk_en |-> crystal_tick || ext_clk_tick)
		else $error("pll fed without high tick");
endmodule // cks_clock_select_asserts
bind cks_clock_select cks_clock_select_asserts cks_clock_select_asserts_inst (.mclk, .nrst, .power_on_clear_option,
	.halt_exec, .stop_exec, .fast_osc_tick, .crystal_tick, .ext_clk_tick, .s_axi_bvalid, .cpu_clk_en,
	.periph_clk_en, .pll_clk_en, .fast_osc_enable, .main_osc_enable, .cpu_state);
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the clock source selection block
`timescale 1ns/1ps
`default_nettype none
`include "cks_params.svh"
module tb_top;
	import cks_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic fast_osc_tick = 1'b0, crystal_tick = 1'b0, ext_clk_tick = 1'b0, halt_exec = 1'b0, stop_exec = 1'b0;
	logic standby_release = 1'b0, power_on_clear_option = 1'b0, supply_above_threshold = 1'b1;
	logic cpu_clk_en, periph_clk_en, pll_clk_en, fast_osc_enable, main_osc_enable, ext_input_enable, amp_high_gain;
	cks_state_t cpu_state;
	logic [7:0] tick_cnt = 8'h00;
	int n_errors = 0, comparisons = 0;
	cks_clock_select cks_clock_select_inst (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.fast_osc_tick, .crystal_tick, .ext_clk_tick, .power_on_clear_option, .supply_above_threshold,
		.halt_exec, .stop_exec, .standby_release, .cpu_clk_en, .periph_clk_en, .pll_clk_en, .fast_osc_enable,
		.main_osc_enable, .ext_input_enable, .amp_high_gain, .cpu_state);
	always #(`CKS_CLK_PERIOD_NS / 2) mclk = ~mclk;
	// co-prime tick spacings so sources rarely line up
	always @(posedge mclk) begin
		tick_cnt <= tick_cnt + 8'h01;
		fast_osc_tick <= (tick_cnt % 2 == 0);
		crystal_tick <= (tick_cnt % 3 == 0);
		ext_clk_tick <= (tick_cnt % 5 == 1);
	end
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_state(input cks_state_t exp, input string what);
		@(negedge mclk);
		comparisons++;
		if (cpu_state !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s state %0d expected %0d", $time, what, cpu_state, exp);
		end
	endtask
	task automatic count_pll(output int n);
		n = 0;
		repeat (15) begin
			@(negedge mclk);
			n += int'(pll_clk_en === 1'b1);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		logic [1:0] r;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge mclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge mclk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
		end while (!b_t);
		s_axi_bready <= 1'b0;
		chk_val({30'h0, r}, {30'h0, `CKS_RESP_OKAY}, "write response");
	endtask
	task automatic rd_raw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_t, r_t;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge mclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge mclk);
			if (ar_t) s_axi_arvalid <= 1'b0;
		end while (!r_t);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd_raw(a, d, r);
		chk_val(d, exp, "read data");
		chk_val({30'h0, r}, {30'h0, `CKS_RESP_OKAY}, "read response");
	endtask
	// which is {stop, halt, release}, one cycle wide
	task automatic strobe(input logic [2:0] which, input cks_state_t exp);
		@(posedge mclk);
		{stop_exec, halt_exec, standby_release} <= which;
		@(posedge mclk);
		{stop_exec, halt_exec, standby_release} <= 3'b000;
		chk_state(exp, "standby step");
	endtask
	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		report_and_stop;
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int cc, pc;
		repeat (3) @(posedge mclk);
		chk_state(CKS_ST_RESET, "in reset");
		@(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		chk_state(CKS_ST_FAST, "after release");
		rd(`CKS_OFS_MAIN_OSC_CTRL, 32'h80);
		rd(`CKS_OFS_MAIN_CLK_MODE, 32'h0);
		rd(`CKS_OFS_OSC_MODE, 32'h0);
		rd(`CKS_OFS_CPU_STATE, 32'h1);
		repeat (70) @(posedge mclk);
		rd(`CKS_OFS_INT_OSC_MODE, 32'h80);
		rd_raw(8'h3C, d, r);
		chk_val({30'h0, r}, {30'h0, `CKS_RESP_SLVERR}, "unmapped response");
		$display("reset and status test done");
		wr(`CKS_OFS_OSC_MODE, 32'h40);
		rd(`CKS_OFS_OSC_MODE, 32'h40);
		wr(`CKS_OFS_OSC_MODE, 32'h41);
		wr(`CKS_OFS_OSC_MODE, 32'h40);
		rd(`CKS_OFS_OSC_MODE, 32'h41);
		chk_val({31'h0, amp_high_gain}, 32'h1, "gain output");
		wr(`CKS_OFS_MAIN_OSC_CTRL, 32'h0);
		chk_val({31'h0, main_osc_enable}, 32'h1, "crystal running");
		do rd_raw(`CKS_OFS_STAB_STATUS, d, r); while (d[0] !== 1'b1);
		count_pll(pc);
		chk_val({31'h0, pc != 0}, 32'h0, "pll idle");
		wr(`CKS_OFS_MAIN_CLK_MODE, 32'h04);
		count_pll(pc);
		chk_val({31'h0, pc != 0}, 32'h1, "pll fed from crystal");
		wr(`CKS_OFS_MAIN_CLK_MODE, 32'h00);
		rd(`CKS_OFS_MAIN_CLK_MODE, 32'h04);
		chk_state(CKS_ST_FAST, "pll set, main clear");
		wr(`CKS_OFS_PROC_CLK_CTRL, 32'h10);
		rd(`CKS_OFS_PROC_CLK_CTRL, 32'h10);
		wr(`CKS_OFS_MAIN_CLK_MODE, 32'h05);
		repeat (8) @(posedge mclk);
		chk_state(CKS_ST_FAST, "cpu select set blocks switch");
		wr(`CKS_OFS_PROC_CLK_CTRL, 32'h00);
		repeat (8) @(posedge mclk);
		chk_state(CKS_ST_HIGH, "crystal switch");
		rd(`CKS_OFS_MAIN_CLK_MODE, 32'h07);
		wr(`CKS_OFS_MAIN_CLK_MODE, 32'h04);
		rd(`CKS_OFS_CPU_STATE, 32'h2);
		$display("crystal switch test done");
		strobe(3'b010, CKS_ST_HALT);
		cc = 0;
		pc = 0;
		repeat (20) begin
			@(negedge mclk);
			cc += int'(cpu_clk_en === 1'b1);
			pc += int'(periph_clk_en === 1'b1);
		end
		chk_val(cc, 32'h0, "cpu pulses in halt");
		chk_val({31'h0, pc != 0}, 32'h1, "peripheral pulses in halt");
		strobe(3'b001, CKS_ST_HIGH);
		strobe(3'b100, CKS_ST_STOP);
		chk_val({30'h0, fast_osc_enable, main_osc_enable}, 32'h0, "oscillators in stop");
		strobe(3'b001, CKS_ST_HIGH);
		wr(`CKS_OFS_INT_OSC_MODE, 32'h1);
		chk_val({31'h0, fast_osc_enable}, 32'h0, "fast oscillator stopped");
		rd(`CKS_OFS_INT_OSC_MODE, 32'h1);
		$display("standby test done");
		@(posedge mclk);
		nrst <= 1'b0;
		power_on_clear_option <= 1'b1;
		supply_above_threshold <= 1'b0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		repeat (20) @(posedge mclk);
		chk_state(CKS_ST_RESET, "supply low");
		@(posedge mclk);
		supply_above_threshold <= 1'b1;
		repeat (494) @(posedge mclk);
		chk_state(CKS_ST_RESET, "before delay ends");
		repeat (10) @(posedge mclk);
		chk_state(CKS_ST_FAST, "after delay");
		wr(`CKS_OFS_OSC_MODE, 32'hC0);
		wr(`CKS_OFS_MAIN_OSC_CTRL, 32'h0);
		chk_val({31'h0, ext_input_enable}, 32'h1, "external input accepted");
		wr(`CKS_OFS_MAIN_CLK_MODE, 32'h04);
		count_pll(pc);
		chk_val({31'h0, pc != 0}, 32'h1, "pll fed from external input");
		wr(`CKS_OFS_MAIN_CLK_MODE, 32'h05);
		repeat (12) @(posedge mclk);
		chk_state(CKS_ST_HIGH, "external switch");
		$display("power-on and external input test done");
		report_and_stop;
	end
endmodule // tb_top
`default_nettype wire
